// >>> hw/branch_move_defs.vh
`ifndef BRANCH_MOVE_DEFS_VH
`define BRANCH_MOVE_DEFS_VH

// ==========================================================================
// Register map (word indices; byte address is index times four)
`define REG_CTRL        4'h0
`define REG_FLAGS       4'h1
`define REG_ACC         4'h2
`define REG_PC          4'h3
`define REG_INSTR       4'h4
`define REG_STATUS      4'h5
`define REG_PSW         4'h6
`define REG_PMEM        4'h7
`define REG_WREG        4'h8
`define REG_RAM         4'h9
`define ADDR_LSB        2
`define ADDR_MSB        5

// ==========================================================================
// Field positions
`define CTRL_BANK       0
`define CTRL_BIGRAM     1
`define FLG_CARRY       0
`define FLG_UFA         1
`define FLG_UFB         2
`define FLG_TOVF        3
`define INSTR_GO        31
`define PSW_BANK_BIT    4
`define PAGE_HI         11
`define PAGE_LO         8
`define WREG_SEL_HI     10
`define WREG_SEL_LO     8
`define RAM_ADDR_HI     14
`define RAM_ADDR_LO     8
`define BYTE_HI         7

// ==========================================================================
// Opcodes
`define OP_BUS_RD       8'h08
`define OP_PORT_RD      8'h09
`define OP_JC           8'hf6
`define OP_JNC          8'he6
`define OP_JUFA         8'hb6
`define OP_JUFB         8'h76
`define OP_INDIRECT_PAGE_BRANCH         8'hb3
`define OP_JIRQL        8'h86
`define OP_JTAL         8'h26
`define OP_JTBL         8'h46
`define OP_JNZ          8'h96
`define OP_JTF          8'h16
`define OP_JTAH         8'h36
`define OP_JTBH         8'h56
`define OP_JZ           8'hc6
`define OP_MOV_IMM      8'h23
`define OP_MOV_PSW      8'hc7
`define PAT_ACCBIT      5'h12
`define PAT_JMP         5'h04
`define PAT_MOVR        5'h1f
`define PAT_MOVIND      7'h78

// ==========================================================================
// Responses and sizes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define RAM_DEPTH       128
`define PC_ONE          12'h001
`define PC_TWO          12'h002
`define ST_IDLE         2'h0
`define ST_CYC1         2'h1
`define ST_CYC2         2'h2

`endif

// >>> hw/branch_cond.v
`timescale 1ns/10ps

// ==========================================================================
// Condition select for conditional page jumps
module branch_cond (
	input  wire [7:0] opcode,
	input  wire [7:0] acc,
	input  wire       carry,
	input  wire       ufa,
	input  wire       ufb,
	input  wire       tovf,
	input  wire       irq_n,
	input  wire       test_a,
	input  wire       test_b,
	output reg        is_cond,
	output reg        taken
);
`include "branch_move_defs.vh"

	always @* begin
		is_cond = 1'b1;
		taken   = 1'b0;
		if (opcode[4:0] == `PAT_ACCBIT)
			taken = acc[opcode[7:5]]; // RULE3
		else begin
			case (opcode)
			`OP_JC:   taken = carry;        // RULE4
			`OP_JNC:  taken = ~carry;       // RULE5
			`OP_JUFA: taken = ufa;          // RULE6
			`OP_JUFB: taken = ufb;          // RULE7
			`OP_JIRQL: taken = ~irq_n;      // RULE10
			`OP_JTAL: taken = ~test_a;      // RULE11
			`OP_JTBL: taken = ~test_b;      // RULE12
			`OP_JNZ:  taken = |acc;         // RULE13
			`OP_JTF:  taken = tovf;         // RULE14
			`OP_JTAH: taken = test_a;       // RULE15
			`OP_JTBH: taken = test_b;       // RULE16
			`OP_JZ:   taken = ~|acc;        // RULE17
			default:  is_cond = 1'b0;
			endcase
		end
	end
endmodule // branch_cond

// >>> hw/branch_and_move_decode.v
`timescale 1ns/10ps

// Notes on behaviour
// RULE1 - Strobed bus read is two cycles; bus value latched as strobe drops; here it is loaded one edge after the strobe rises.
// RULE2 - Plain port read loads bus value like strobed read, never strobes.
// RULE3 - Accumulator-bit jump: bit from opcode 7-5; set loads PC low byte.
// RULE4 - Carry-set jump, two cycles, loads PC low byte when carry is one.
// RULE5 - Carry-clear jump loads PC low byte when carry zero, else PC+2.
// RULE6 - First user flag jump branches in page when flag is one.
// RULE7 - Second user flag jump branches in page when flag is one.
// RULE8 - Direct jump loads PC 10-0 from instruction, PC 11 from bank flip-flop.
// RULE9 - Indirect page jump loads PC low byte from page byte at accumulator; here it comes from the PMEM register, accumulator unused.
// RULE10 - Interrupt-low jump branches when interrupt input low, else PC+2.
// RULE11 - First test pin low jump branches when pin low, else PC+2.
// RULE12 - Second test pin low jump branches when pin low, else PC+2.
// RULE13 - Nonzero jump branches when accumulator is nonzero.
// RULE14 - Timer flag jump branches when flag set and always clears it.
// RULE15 - First test pin high jump branches when pin high.
// RULE16 - Second test pin high jump branches when pin high.
// RULE17 - Zero jump branches when accumulator is all zeros.
// RULE18 - Immediate load is two cycles, writes data byte to accumulator.
// RULE19 - Status read copies whole status word, bank bit 4, into accumulator.
// RULE20 - Register read copies selected working register into accumulator.
// RULE21 - Indirect read uses R0/R1 bits 0-5, or 0-6 large; pointer unchanged.
// RULE22 - Other single-byte instructions here take one cycle, PC plus one.
// RULE23 - Bank flip-flop for PC bit 11 set by latest bank select.
module branch_and_move_decode (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [7:0]  bus_port,
	input  wire        test_pin_a,
	input  wire        test_pin_b,
	input  wire        irq_n,
	output reg         read_strobe_n,
	output reg         busy
);
`include "branch_move_defs.vh"

	// ======================================================================
	// Pin synchronisers
	reg  [7:0] bus_s1_reg, bus_s2_reg;
	reg  [2:0] pin_s1_reg, pin_s2_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			bus_s1_reg <= 8'h00;
			bus_s2_reg <= 8'h00;
			pin_s1_reg <= 3'h7;
			pin_s2_reg <= 3'h7;
		end else begin
			bus_s1_reg <= bus_port;
			bus_s2_reg <= bus_s1_reg;
			pin_s1_reg <= {irq_n, test_pin_b, test_pin_a};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// ======================================================================
	// Core state
	reg  [7:0]  acc_reg;
	reg  [11:0] pc_reg;
	reg  [7:0]  psw_reg;
	reg         bank_ff_reg;
	reg         big_ram_reg;
	reg         carry_reg, ufa_reg, ufb_reg, tovf_reg;
	reg  [15:0] instr_reg;
	reg  [1:0]  state_reg;
	reg  [7:0]  pmem_reg;
	reg  [7:0]  wreg_mem [0:7];
	reg  [7:0]  ram_mem  [0:`RAM_DEPTH-1];

	wire [7:0]  op  = instr_reg[15:8];
	wire [7:0]  arg = instr_reg[7:0];
	wire        cond_inst;
	wire        cond_taken;

	branch_cond i_branch_cond (
		.opcode  (op),
		.acc     (acc_reg),
		.carry   (carry_reg),
		.ufa     (ufa_reg),
		.ufb     (ufb_reg),
		.tovf    (tovf_reg),
		.irq_n   (pin_s2_reg[2]),
		.test_a  (pin_s2_reg[0]),
		.test_b  (pin_s2_reg[1]),
		.is_cond (cond_inst),
		.taken   (cond_taken)
	);

	// Two-cycle instructions in this group
	function two_cycle;
		input [7:0] o;
		begin
			two_cycle = (o == `OP_BUS_RD) || (o == `OP_PORT_RD) ||
				(o == `OP_MOV_IMM) || (o == `OP_INDIRECT_PAGE_BRANCH) ||
				(o[4:0] == `PAT_JMP) || (o[4:0] == `PAT_ACCBIT) ||
				(o == `OP_JC) || (o == `OP_JNC) || (o == `OP_JUFA) ||
				(o == `OP_JUFB) || (o == `OP_JIRQL) || (o == `OP_JTAL) ||
				(o == `OP_JTBL) || (o == `OP_JNZ) || (o == `OP_JTF) ||
				(o == `OP_JTAH) || (o == `OP_JTBH) || (o == `OP_JZ);
		end
	endfunction

	// Indirect RAM address from pointer register
	function [6:0] ram_addr;
		input [7:0] ptr;
		input       big;
		begin
			ram_addr = big ? ptr[6:0] : {1'b0, ptr[5:0]}; // RULE21
		end
	endfunction

	// ======================================================================
	// AXI4-Lite slave
	reg        aw_got_reg, w_got_reg;
	reg  [5:0] aw_addr_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0] w_strb_reg;
	// Response once both channels are held, in either order
	wire       wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
	wire [3:0] wr_idx  = aw_addr_reg[`ADDR_MSB:`ADDR_LSB];
	wire       go      = wr_fire && (wr_idx == `REG_INSTR) && w_strb_reg[3] &&
		w_data_reg[`INSTR_GO] && (state_reg == `ST_IDLE);
	wire [3:0] rd_idx  = s_axi_araddr[`ADDR_MSB:`ADDR_LSB];
	wire       wreg_load;
	wire       ram_load;

	// Software write of one register index on the low byte lane
	function wr_hit;
		input [3:0] idx;
		begin
			wr_hit = wr_fire && (wr_idx == idx) && w_strb_reg[0];
		end
	endfunction

	assign wreg_load = wr_hit(`REG_WREG);
	assign ram_load  = wr_hit(`REG_RAM);

	// ======================================================================
	// Register read mux; working registers and RAM are write-only
	reg  [31:0] rd_word;
	reg         rd_bad;

	always @* begin
		rd_word = 32'h0000_0000;
		rd_bad  = 1'b0;
		case (rd_idx)
		`REG_CTRL:   rd_word = {30'h0, big_ram_reg, bank_ff_reg};
		`REG_FLAGS:  rd_word = {28'h0, tovf_reg, ufb_reg, ufa_reg, carry_reg};
		`REG_ACC:    rd_word = {24'h0, acc_reg};
		`REG_PC:     rd_word = {20'h0, pc_reg};
		`REG_INSTR:  rd_word = {16'h0, instr_reg};
		`REG_STATUS: rd_word = {29'h0, pin_s2_reg};
		`REG_PSW:    rd_word = {24'h0, psw_reg};
		`REG_PMEM:   rd_word = {24'h0, pmem_reg};
		default:     rd_bad  = 1'b1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			aw_got_reg    <= 1'b0;
			w_got_reg     <= 1'b0;
			aw_addr_reg   <= 6'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg    <= 1'b1;
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg    <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx <= `REG_RAM) ? `RESP_OKAY : `RESP_SLVERR;
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_bad ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Working registers and resident RAM, software loads
	always @(posedge aclk) begin
		if (wreg_load)
			wreg_mem[w_data_reg[`WREG_SEL_HI:`WREG_SEL_LO]] <= w_data_reg[`BYTE_HI:0];
		if (ram_load)
			ram_mem[w_data_reg[`RAM_ADDR_HI:`RAM_ADDR_LO]] <= w_data_reg[`BYTE_HI:0];
	end

	// ======================================================================
	// Deferred bus port load
	// The bus reaches the second synchroniser stage two edges late, so the
	// value that stood while the strobe was low is loaded one edge after it rises.
	wire        bus_cycle = (op == `OP_BUS_RD) || (op == `OP_PORT_RD);
	reg         bus_load_reg;

	always @(posedge aclk) begin
		if (!aresetn)
			bus_load_reg <= 1'b0;
		else
			bus_load_reg <= (state_reg == `ST_CYC2) && bus_cycle; // RULE1 RULE2
	end

	// ======================================================================
	// Execution sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			acc_reg       <= 8'h00;
			pc_reg        <= 12'h000;
			psw_reg       <= 8'h00;
			bank_ff_reg   <= 1'b0;
			big_ram_reg   <= 1'b0;
			carry_reg     <= 1'b0;
			ufa_reg       <= 1'b0;
			ufb_reg       <= 1'b0;
			tovf_reg      <= 1'b0;
			instr_reg     <= 16'h0000;
			pmem_reg      <= 8'h00;
			state_reg     <= `ST_IDLE;
			read_strobe_n <= 1'b1;
			busy          <= 1'b0;
		end else begin
			if (wr_fire && w_strb_reg[0]) begin
				case (wr_idx)
				`REG_CTRL: begin
					bank_ff_reg <= w_data_reg[`CTRL_BANK]; // RULE23
					big_ram_reg <= w_data_reg[`CTRL_BIGRAM];
				end
				`REG_FLAGS: begin
					carry_reg <= w_data_reg[`FLG_CARRY];
					ufa_reg   <= w_data_reg[`FLG_UFA];
					ufb_reg   <= w_data_reg[`FLG_UFB];
					tovf_reg  <= w_data_reg[`FLG_TOVF];
				end
				`REG_ACC:  acc_reg  <= w_data_reg[7:0];
				`REG_PSW:  psw_reg  <= w_data_reg[7:0];
				`REG_PMEM: pmem_reg <= w_data_reg[7:0];
				`REG_PC: begin
					if (w_strb_reg[1])
						pc_reg <= w_data_reg[11:0];
				end
				default: ;
				endcase
			end
			if (go) begin
				instr_reg <= w_data_reg[15:0];
				state_reg <= `ST_CYC1;
				busy      <= 1'b1;
				if (w_data_reg[15:8] == `OP_BUS_RD)
					read_strobe_n <= 1'b0; // RULE1
			end
			case (state_reg)
			`ST_IDLE: ;
			`ST_CYC1: begin
				if (two_cycle(op))
					state_reg <= `ST_CYC2;
				else begin
					state_reg <= `ST_IDLE;
					busy      <= 1'b0;
					pc_reg    <= pc_reg + `PC_ONE; // RULE22
					if (op == `OP_MOV_PSW)
						acc_reg <= psw_reg; // RULE19
					else if (op[7:3] == `PAT_MOVR)
						acc_reg <= wreg_mem[op[2:0]]; // RULE20
					else if (op[7:1] == `PAT_MOVIND)
						acc_reg <= ram_mem[ram_addr(wreg_mem[{2'b00, op[0]}],
							big_ram_reg)]; // RULE21
				end
			end
			`ST_CYC2: begin
				state_reg     <= `ST_IDLE;
				busy          <= 1'b0;
				read_strobe_n <= 1'b1;
				pc_reg        <= pc_reg + `PC_TWO;
				if (op == `OP_MOV_IMM)
					acc_reg <= arg; // RULE18
				else if (op == `OP_INDIRECT_PAGE_BRANCH)
					pc_reg <= {pc_reg[`PAGE_HI:`PAGE_LO], pmem_reg}; // RULE9
				else if (op[4:0] == `PAT_JMP)
					pc_reg <= {bank_ff_reg, op[7:5], arg}; // RULE8
				else if (cond_inst) begin
					if (cond_taken)
						pc_reg <= {pc_reg[`PAGE_HI:`PAGE_LO], arg};
					// After the software write, so the clear wins
					if (op == `OP_JTF)
						tovf_reg <= 1'b0; // RULE14
				end
			end
			default: state_reg <= `ST_IDLE;
			endcase
			// Last, so the synchronised bus value wins over a software load
			if (bus_load_reg)
				acc_reg <= bus_s2_reg; // RULE1 RULE2
		end
	end
endmodule // branch_and_move_decode

// >>> tb/bmd_pins.sv
`timescale 1ns/10ps
// ====
// Bus peripheral and pin levels
module bmd_pins (
	input  wire       aclk,
	input  wire       read_strobe_n,
	input  wire       pmode,
	input  wire [7:0] pdata,
	input  wire [2:0] lvl,
	output wire [7:0] bus_port,
	output wire       test_pin_a,
	output wire       test_pin_b,
	output wire       irq_n
);
	reg [2:0] hold = 3'h0;
	always @(posedge aclk)
		hold <= !read_strobe_n ? 3'h4 : hold - {2'b0, hold != 3'h0};
	// Released bus shows the inverse once the hold count has run down from 4, unless pmode is set
	assign bus_port = (pmode || !read_strobe_n || hold != 3'h0) ? pdata : ~pdata;
	assign {irq_n, test_pin_b, test_pin_a} = lvl;
endmodule // bmd_pins

// >>> tb/branch_and_move_decode_checker.sv
`timescale 1ns/10ps
`include "branch_move_defs.vh"
module branch_and_move_decode_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire [5:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [5:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        read_strobe_n,
	input wire        busy
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ====
	// Instruction launch and run lengths
	wire go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !busy
		&& s_axi_awaddr[`ADDR_MSB:`ADDR_LSB] == `REG_INSTR && s_axi_wdata[`INSTR_GO];
	wire [7:0] opc = s_axi_wdata[15:8];
	wire jmp2 = opc == `OP_JC || opc == `OP_JUFA || opc == `OP_JUFB || opc == `OP_INDIRECT_PAGE_BRANCH;
	sequence run2;
		$rose(busy) ##2 $fell(busy);
	endsequence
	sequence run1;
		$rose(busy) ##1 $fell(busy);
	endsequence
	strobe_busy_a: assert property (!read_strobe_n |-> busy)
		else $error("strobe without busy");
	strobe_len_a: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*2] ##1
		(read_strobe_n && $fell(busy))) else $error("strobe length");
	bus_rd_a: assert property (go && opc == `OP_BUS_RD |-> ##[1:3] $fell(read_strobe_n))
		else $error("no strobe");
	port_rd_a: assert property (go && opc == `OP_PORT_RD |=> read_strobe_n [*5])
		else $error("strobe on port read");
	jump_len_a: assert property (go && jmp2 |-> ##[1:3] run2)
		else $error("jump length");
	imm_len_a: assert property (go && opc == `OP_MOV_IMM |-> ##[1:3] run2)
		else $error("immediate length");
	psw_len_a: assert property (go && opc == `OP_MOV_PSW |-> ##[1:3] run1)
		else $error("status read length");
	rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[`ADDR_MSB:`ADDR_LSB] > `REG_PMEM
		|=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read");
endmodule // branch_and_move_decode_checker

// >>> tb/branch_and_move_decode_tb.sv
`timescale 1ns/10ps
`include "branch_move_defs.vh"
module branch_and_move_decode_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, pmode = 1'b0;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, rv;
	logic [7:0]  pdata = 8'h00;
	logic [2:0]  lvl = 3'h0;
	logic [1:0]  rr;
	logic [12:0] amask = 13'h0f1d;
	logic [7:0]  jop [13];
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         read_strobe_n, busy, test_pin_a, test_pin_b, irq_n;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [7:0]  bus_port;
	int          mismatches = 0, total_checks = 0;

	always #10 aclk = ~aclk;
	branch_and_move_decode i_branch_and_move_decode (.*);
	bmd_pins i_bmd_pins (.*);

	// ====
	// Bus tasks
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {a, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		#1;
		while (s_axi_awvalid || s_axi_wvalid) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			#1;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= {a, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// Program state, run one instruction, compare results
	task automatic op(input logic [7:0] o, b, ac, eac, input logic [11:0] pc, epc,
			input logic [3:0] fl);
		wr(`REG_FLAGS, {28'h0, fl});
		wr(`REG_ACC, {24'h0, ac});
		wr(`REG_PC, {20'h0, pc});
		wr(`REG_INSTR, {16'h8000, o, b});
		repeat (3) @(posedge aclk);
		while (busy !== 1'b0) @(posedge aclk);
		rd(`REG_ACC);
		chk("acc", {24'h0, eac}, rv);
		rd(`REG_PC);
		chk("pc", {20'h0, epc}, rv);
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ====
	// Tests
	initial begin
		jop = '{`OP_JC, `OP_JNC, `OP_JUFA, `OP_JUFB, `OP_JIRQL,
			`OP_JTAL, `OP_JTBL, `OP_JNZ, `OP_JTF,
			`OP_JTAH, `OP_JTBH, `OP_JZ, {3'd4, `PAT_ACCBIT}};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			lvl <= s ? 3'b100 : 3'b011;
			for (int i = 0; i < 13; i++) begin
				op(jop[i], 8'h3c, s ? 8'hff : 8'h00, s ? 8'hff : 8'h00, 12'h5fe,
					(amask[i] ^ s[0]) ? 12'h53c : 12'h600, s ? 4'h0 : 4'hf);
				if (jop[i] == `OP_JTF) begin
					rd(`REG_FLAGS);
					chk("flags", s ? 32'h0 : 32'h7, rv);
				end
			end
		end
		rd(`REG_STATUS);
		chk("status", 32'h4, rv);
		wr(`REG_PMEM, 32'h77);
		op(`OP_INDIRECT_PAGE_BRANCH, 8'h00, 8'h0f, 8'h0f, 12'h2a0, 12'h277, 4'h0);
		wr(`REG_CTRL, 32'h1);
		op({3'd5, `PAT_JMP}, 8'h34, 8'h00, 8'h00, 12'h0f0, 12'hd34, 4'h0);
		wr(`REG_CTRL, 32'h0);
		op({3'd5, `PAT_JMP}, 8'h34, 8'h00, 8'h00, 12'h8f0, 12'h534, 4'h0);
		pdata <= 8'h5a;
		op(`OP_BUS_RD, 8'h00, 8'h11, 8'h5a, 12'h100, 12'h102, 4'h0);
		pmode <= 1'b1;
		pdata <= 8'ha6;
		op(`OP_PORT_RD, 8'h00, 8'h11, 8'ha6, 12'h100, 12'h102, 4'h0);
		op(`OP_MOV_IMM, 8'hc5, 8'h00, 8'hc5, 12'h3fe, 12'h400, 4'h0);
		wr(`REG_PSW, 32'h13);
		op(`OP_MOV_PSW, 8'h00, 8'h00, 8'h13, 12'h0ff, 12'h100, 4'h0);
		for (int r = 0; r < 8; r++)
			wr(`REG_WREG, {21'h0, r[2:0], 5'h10, r[2:0]});
		for (int r = 0; r < 8; r++)
			op({`PAT_MOVR, r[2:0]}, 8'h0, 8'h0, {5'h10, r[2:0]}, 12'h0, 12'h1, 4'h0);
		wr(`REG_WREG, {21'h0, 3'd0, 8'h3f});
		wr(`REG_WREG, {21'h0, 3'd1, 8'hff});
		wr(`REG_RAM, {17'h0, 7'h3f, 8'hc3});
		wr(`REG_RAM, {17'h0, 7'h7f, 8'h3c});
		op({`PAT_MOVIND, 1'b0}, 8'h0, 8'h0, 8'hc3, 12'h0, 12'h1, 4'h0);
		op({`PAT_MOVIND, 1'b1}, 8'h0, 8'h0, 8'hc3, 12'h0, 12'h1, 4'h0);
		wr(`REG_CTRL, 32'h2);
		op({`PAT_MOVIND, 1'b1}, 8'h0, 8'h0, 8'h3c, 12'h0, 12'h1, 4'h0);
		op({`PAT_MOVR, 3'd1}, 8'h0, 8'h0, 8'hff, 12'h0, 12'h1, 4'h0);
		wr(4'ha, 32'h0);
		chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, rr});
		rd(4'hf);
		chk("rresp", {30'h0, `RESP_SLVERR}, {30'h0, rr});
		chk("rdata", 32'h0, rv);
		rd(`REG_RAM);
		chk("rresp", {30'h0, `RESP_SLVERR}, {30'h0, rr});
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		print_verdict();
	end
endmodule // branch_and_move_decode_tb

bind branch_and_move_decode branch_and_move_decode_checker
	i_branch_and_move_decode_checker (.*);
